// ===== hw/rpcf_pkg.sv
// Package of constants and carrier types for the root port change flags.
// Function
// - Set reset-done change after 10 ms reset.
// - Write one clears change flag; zero ignored.
// - Overcurrent indicator change sets bit 19.
// - Resume done after pulse, EOP, 3 ms.
// - Setting reset-done change clears resume-done.
// - Hardware enable loss sets bit 17.
// - Attach or detach sets bit 16.
// - Port command while disconnected sets bit 16.
// - Fixed device: bit 16 only after hub reset.
// - Bit 9 reads low-speed attached.
// - Write one to bit 9 powers off.
// - Writes wait for transaction to finish.
package rpcf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_STATUS = 8'h15;
  localparam logic [7:0] ADDR_PORT_WRITE  = 8'h95;
  localparam int BIT_RESET_DONE  = 20;
  localparam int BIT_OC_CHANGE   = 19;
  localparam int BIT_RESUME_DONE = 18;
  localparam int BIT_ENABLE_LOST = 17;
  localparam int BIT_ATTACH      = 16;
  localparam int BIT_SLOW_DEV    = 9;
  localparam int BIT_PORT_ENABLE  = 1;
  localparam int BIT_PORT_SUSPEND = 2;
  localparam int BIT_PORT_RESET   = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int RESET_TIME_MS  = 10;
  localparam int RESYNC_TIME_MS = 3;
  localparam int RESET_CYCLES   = RESET_TIME_MS * 1000 * 1000 / 10;
  localparam int RESYNC_CYCLES  = RESYNC_TIME_MS * 1000 * CLK_MHZ;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rpcf_bus_t;
  typedef struct packed {
    logic device_present;
    logic port_enabled;
    logic port_overcurrent_flag;
    logic slow_device_attached;
    logic fixed_device;
  } rpcf_port_t;
endpackage

// ===== hw/rpcf_flag.sv
// One sticky change flag with set-over-clear priority.
`timescale 1ns/1ps
module rpcf_flag (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (set) begin
        flag <= 1'b1;
      end else if (clr) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

// ===== hw/rpcf_top.sv
// Root port change flags: status-change bits, low-speed bit and write handling.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rpcf_top
  import rpcf_pkg::*;
#(
  parameter int RESET_CNT  = rpcf_pkg::RESET_CYCLES,
  parameter int RESYNC_CNT = rpcf_pkg::RESYNC_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire rpcf_pkg::rpcf_bus_t  bus,
  output logic [31:0]            rdata,
  input  wire rpcf_pkg::rpcf_port_t port_pins,
  input  wire logic              per_port_oc,
  input  wire logic              hw_enable_loss,
  input  wire logic              hub_reset_done,
  input  wire logic              resume_eop_done,
  input  wire logic              xfer_busy,
  output logic                   port_reset_active,
  output logic                   cmd_port_enable,
  output logic                   cmd_port_suspend,
  output logic                   cmd_port_power_off
);
  import rpcf_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  rpcf_port_t pin_meta;
  rpcf_port_t pins;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_meta <= '0;
      pins     <= '0;
    end else if (ce) begin
      pin_meta <= port_pins;
      pins     <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Postponed write
  // ----------------------------------------------------------------
  // A write during a transaction is held so the port never sees a
  // status change in the middle of a token-to-handshake exchange.
  logic        pend;
  logic [31:0] pend_data;
  logic        apply;
  logic [31:0] wdata;
  wire         wr_hit = bus.wr && bus.addr == ADDR_PORT_WRITE;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend      <= 1'b0;
      pend_data <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_hit && (xfer_busy || pend)) begin
        pend      <= 1'b1;
        pend_data <= bus.wdata;
      end else if (!xfer_busy) begin
        pend <= 1'b0;
      end
    end
  end
  always_comb begin
    apply = 1'b0;
    wdata = 32'h0000_0000;
    // A held write goes first; a new write meeting it waits one cycle, so neither is lost.
    if (!xfer_busy) begin
      if (pend) begin
        apply = 1'b1;
        wdata = pend_data;
      end else if (wr_hit) begin
        apply = 1'b1;
        wdata = bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  logic cmd_reset;
  logic cmd_any;
  assign cmd_reset = apply && wdata[BIT_PORT_RESET];
  assign cmd_any   = apply && (wdata[BIT_PORT_RESET] || wdata[BIT_PORT_ENABLE]
                     || wdata[BIT_PORT_SUSPEND]);
  // Enable, suspend and reset commands to an empty port are dropped (power-off is passed on); the attach change flag tells the driver why.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_port_enable <= 1'b0;
    end else if (ce) begin
      cmd_port_enable <= apply && wdata[BIT_PORT_ENABLE] && pins.device_present;
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_port_suspend <= 1'b0;
    end else if (ce) begin
      cmd_port_suspend <= apply && wdata[BIT_PORT_SUSPEND] && pins.device_present;
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_port_power_off <= 1'b0;
    end else if (ce) begin
      cmd_port_power_off <= apply && wdata[BIT_SLOW_DEV];
    end
  end

  // ----------------------------------------------------------------
  // Port reset timer
  // ----------------------------------------------------------------
  logic [31:0] rst_cnt;
  logic        reset_end;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      port_reset_active <= 1'b0;
      rst_cnt           <= 32'h0000_0000;
    end else if (ce) begin
      if (cmd_reset && pins.device_present && !port_reset_active) begin
        port_reset_active <= 1'b1;
        rst_cnt           <= 32'(RESET_CNT - 1);
      end else if (port_reset_active) begin
        if (rst_cnt == 32'h0000_0000) begin
          port_reset_active <= 1'b0;
        end else begin
          rst_cnt <= rst_cnt - 32'h0000_0001;
        end
      end
    end
  end
  assign reset_end = port_reset_active && rst_cnt == 32'h0000_0000;

  // ----------------------------------------------------------------
  // Resume timer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RPCF_IDLE, RPCF_RESYNC} rpcf_res_t;
  rpcf_res_t   res_state;
  logic [31:0] res_cnt;
  logic        resume_end;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      res_state <= RPCF_IDLE;
      res_cnt   <= 32'h0000_0000;
    end else if (ce) begin
      case (res_state)
        RPCF_IDLE: begin
          if (resume_eop_done) begin
            res_state <= RPCF_RESYNC;
            res_cnt   <= 32'(RESYNC_CNT - 1);
          end
        end
        RPCF_RESYNC: begin
          if (res_cnt == 32'h0000_0000) begin
            res_state <= RPCF_IDLE;
          end else begin
            res_cnt <= res_cnt - 32'h0000_0001;
          end
        end
        default: begin
          res_state <= RPCF_IDLE;
        end
      endcase
    end
  end
  assign resume_end = res_state == RPCF_RESYNC && res_cnt == 32'h0000_0000;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic prev_present;
  logic prev_oc;
  logic fixed_armed;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prev_present <= 1'b0;
      prev_oc      <= 1'b0;
    end else if (ce) begin
      prev_present <= pins.device_present;
      prev_oc      <= pins.port_overcurrent_flag;
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fixed_armed <= 1'b1;
    end else if (ce) begin
      if (hub_reset_done) begin
        fixed_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Change flags
  // ----------------------------------------------------------------
  // Set beats clear inside each flag, so an event never slips past a clear.
  logic [4:0] set_v;
  logic [4:0] clr_v;
  logic [4:0] flags;
  logic       conn_evt;
  always_comb begin
    conn_evt = pins.device_present != prev_present;
    if (pins.fixed_device) begin
      conn_evt = hub_reset_done && fixed_armed && pins.device_present;
    end
    set_v    = FLAGS_RESET;
    set_v[4] = reset_end;
    set_v[3] = per_port_oc && pins.port_overcurrent_flag != prev_oc;
    set_v[2] = resume_end && !reset_end;
    set_v[1] = hw_enable_loss && pins.port_enabled;
    set_v[0] = conn_evt || (cmd_any && !pins.device_present);
    clr_v    = apply ? wdata[BIT_RESET_DONE:BIT_ATTACH] : FLAGS_RESET;
    clr_v[2] = clr_v[2] || reset_end;
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_flag
      rpcf_flag u_flag (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .set   (set_v[g]),
        .clr   (clr_v[g]),
        .flag  (flags[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (bus.rd && bus.addr == ADDR_PORT_STATUS) begin
        rdata[BIT_RESET_DONE:BIT_ATTACH] <= flags;
        rdata[BIT_SLOW_DEV] <= pins.slow_device_attached && pins.device_present;
        rdata[BIT_PORT_RESET]  <= port_reset_active;
        rdata[BIT_PORT_ENABLE] <= pins.port_enabled;
        rdata[0]               <= pins.device_present;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_flag_set_a: assert property (@(posedge mclk) disable iff (reset)
    ce && reset_end |=> flags[4] && !flags[2])
    else $error("reset-done change not set at reset end");
  write_clear_a: assert property (@(posedge mclk) disable iff (reset)
    ce && apply && wdata[BIT_ATTACH] && !set_v[0] |=> !flags[0])
    else $error("attach change not cleared by write");
  zero_keep_a: assert property (@(posedge mclk) disable iff (reset)
    ce && flags[3] && !(apply && wdata[BIT_OC_CHANGE]) |=> flags[3])
    else $error("overcurrent change lost without clear");
  oc_change_a: assert property (@(posedge mclk) disable iff (reset)
    ce && per_port_oc && $changed(pins.port_overcurrent_flag) |=> flags[3])
    else $error("overcurrent change not flagged");
  resume_done_a: assert property (@(posedge mclk) disable iff (reset)
    ce && resume_end && !reset_end |=> flags[2])
    else $error("resume-done change not set");
  enable_lost_a: assert property (@(posedge mclk) disable iff (reset)
    ce && set_v[1] |=> flags[1])
    else $error("enable-lost change not set");
  idle_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    ce && cmd_any && !pins.device_present |=> flags[0])
    else $error("command while disconnected not flagged");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (reset)
    rdata[31:21] == 11'h000 && rdata[15:10] == 6'h00)
    else $error("reserved bits not zero");
  busy_hold_a: assert property (@(posedge mclk) disable iff (reset)
    ce && wr_hit && xfer_busy |=> pend || !xfer_busy)
    else $error("write during transaction not postponed");
  attach_event_a: assert property (@(posedge mclk) disable iff (reset)
    ce && !pins.fixed_device && $changed(pins.device_present) |=> flags[0])
    else $error("attach or detach not flagged");
  fixed_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    ce && pins.fixed_device && !hub_reset_done && !cmd_any && !flags[0] |=> !flags[0])
    else $error("fixed device flagged without hub reset");
  fixed_announce_a: assert property (@(posedge mclk) disable iff (reset)
    ce && pins.fixed_device && hub_reset_done && fixed_armed && pins.device_present
    |=> flags[0])
    else $error("fixed device not announced after hub reset");
  slow_read_a: assert property (@(posedge mclk) disable iff (reset)
    ce && bus.rd && bus.addr == ADDR_PORT_STATUS && pins.device_present
    && pins.slow_device_attached |=> rdata[BIT_SLOW_DEV])
    else $error("low-speed device not reported");
  slow_gone_a: assert property (@(posedge mclk) disable iff (reset)
    ce && bus.rd && bus.addr == ADDR_PORT_STATUS && !pins.device_present
    |=> !rdata[BIT_SLOW_DEV])
    else $error("low-speed bit set with no device");
  reset_load_a: assert property (@(posedge mclk) disable iff (reset)
    ce && cmd_reset && !port_reset_active && pins.device_present
    |=> port_reset_active && rst_cnt == 32'(RESET_CNT - 1))
    else $error("port reset timer not started");
  resume_load_a: assert property (@(posedge mclk) disable iff (reset)
    ce && res_state == RPCF_IDLE && resume_eop_done
    |=> res_state == RPCF_RESYNC && res_cnt == 32'(RESYNC_CNT - 1))
    else $error("resync delay not started");
  resume_blocked_a: assert property (@(posedge mclk) disable iff (reset)
    ce && reset_end && resume_end |=> !flags[2])
    else $error("resume-done change kept beside reset-done change");
  oc_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    ce && !per_port_oc && !flags[3] |=> !flags[3])
    else $error("overcurrent change set without per-port reporting");
  enable_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    ce && !hw_enable_loss && !flags[1] |=> !flags[1])
    else $error("enable-lost change set without hardware loss");
  reset_refused_a: assert property (@(posedge mclk) disable iff (reset)
    ce && cmd_reset && !pins.device_present && !port_reset_active |=> !port_reset_active)
    else $error("reset started on an empty port");
  enable_refused_a: assert property (@(posedge mclk) disable iff (reset)
    ce && apply && !pins.device_present |=> !cmd_port_enable && !cmd_port_suspend)
    else $error("command passed to an empty port");
  power_off_a: assert property (@(posedge mclk) disable iff (reset)
    ce && apply && wdata[BIT_SLOW_DEV] |=> cmd_port_power_off)
    else $error("power-off write not passed on");
  power_keep_a: assert property (@(posedge mclk) disable iff (reset)
    ce && !(apply && wdata[BIT_SLOW_DEV]) |=> !cmd_port_power_off)
    else $error("power-off issued without a write of one");
  set_wins_a: assert property (@(posedge mclk) disable iff (reset)
    ce && set_v[0] && clr_v[0] |=> flags[0])
    else $error("clear beat a same-cycle attach event");
  pend_keep_a: assert property (@(posedge mclk) disable iff (reset)
    ce && pend && xfer_busy |=> pend)
    else $error("held write dropped during transaction");
  attach_hold_a: assert property (@(posedge mclk) disable iff (reset)
    ce && flags[0] && !(apply && wdata[BIT_ATTACH]) |=> flags[0])
    else $error("attach change lost without clear");
  enable_hold_a: assert property (@(posedge mclk) disable iff (reset)
    ce && flags[1] && !(apply && wdata[BIT_ENABLE_LOST]) |=> flags[1])
    else $error("enable-lost change lost without clear");
  resume_hold_a: assert property (@(posedge mclk) disable iff (reset)
    ce && flags[2] && !reset_end && !(apply && wdata[BIT_RESUME_DONE]) |=> flags[2])
    else $error("resume-done change lost without clear");
  done_hold_a: assert property (@(posedge mclk) disable iff (reset)
    ce && flags[4] && !(apply && wdata[BIT_RESET_DONE]) |=> flags[4])
    else $error("reset-done change lost without clear");
  read_idle_a: assert property (@(posedge mclk) disable iff (reset)
    ce && !(bus.rd && bus.addr == ADDR_PORT_STATUS) |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  freeze_hold_a: assert property (@(posedge mclk) disable iff (reset)
    !ce |=> $stable(flags))
    else $error("flags moved while clock enable low");
endmodule

// ===== tb/rpcf_dev_model.sv
// Behavioural model of the device attached to the downstream port.
`timescale 1ns/1ps
module rpcf_dev_model (
  input  wire logic           mclk,
  input  wire logic           plugged,
  input  wire logic           slow,
  input  wire logic           oc,
  input  wire logic           fixed,
  input  wire logic           resetting,
  output rpcf_pkg::rpcf_port_t pins
);
  import rpcf_pkg::*;
  logic en = 1'b0;
  logic was_rst = 1'b0;
  // The port only comes up after a finished reset, and drops as soon as the device leaves.
  always @(posedge mclk) begin
    was_rst <= resetting;
    if (!plugged) en <= 1'b0;
    else if (was_rst && !resetting) en <= 1'b1;
  end
  assign pins = '{plugged, en, oc, slow, fixed};
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the root port change flags.
`timescale 1ns/1ps
module tb_top;
  import rpcf_pkg::*;
  localparam int RST_N = 20;
  localparam int RSY_N = 10;
  localparam logic [31:0] CLR = 32'h001F_0000;
  logic mclk = 1'b0, reset = 1'b1, plugged = 1'b0, slow = 1'b0, oc = 1'b0, fixed = 1'b0;
  logic per_port_oc = 1'b0, hw_enable_loss = 1'b0, hub_reset_done = 1'b0;
  logic resume_eop_done = 1'b0, xfer_busy = 1'b0, ce = 1'b1;
  rpcf_bus_t bus = '0;
  rpcf_port_t pins;
  logic [31:0] rdata;
  logic rst_act, c_en, c_sus, c_off;
  int err_total = 0, samples_checked = 0, cyc = 0, n_en = 0, n_off = 0, n_sus = 0;
  int port_cmd [3] = '{BIT_PORT_ENABLE, BIT_PORT_SUSPEND, BIT_PORT_RESET};
  always #5 mclk = ~mclk;
  rpcf_top #(.RESET_CNT(RST_N), .RESYNC_CNT(RSY_N)) u_dut (
    .mclk(mclk), .reset(reset), .ce(ce), .bus(bus), .rdata(rdata), .port_pins(pins),
    .per_port_oc(per_port_oc), .hw_enable_loss(hw_enable_loss),
    .hub_reset_done(hub_reset_done), .resume_eop_done(resume_eop_done),
    .xfer_busy(xfer_busy), .port_reset_active(rst_act), .cmd_port_enable(c_en),
    .cmd_port_suspend(c_sus), .cmd_port_power_off(c_off));
  rpcf_dev_model u_dev (.mclk(mclk), .plugged(plugged), .slow(slow), .oc(oc),
    .fixed(fixed), .resetting(rst_act), .pins(pins));
  // Pulses last one cycle, so they are counted rather than sampled by the sequence.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    n_en <= n_en + int'(c_en);
    n_off <= n_off + int'(c_off);
    n_sus <= n_sus + int'(c_sus);
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge mclk);
    bus <= '{ADDR_PORT_WRITE, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask
  // Only bits 31 to 9 are compared; the lower status bits 4, 1 and 0 (reset, enable, connect) are left unchecked.
  task automatic rd(input logic [7:0] a, input logic [4:0] f, input logic s);
    @(posedge mclk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
    chk(rdata & 32'hFFFF_FE00, {11'h0, f, 6'h0, s, 9'h0});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rd(ADDR_PORT_STATUS, 5'h00, 1'b0);
    rd(8'h33, 5'h00, 1'b0);
    plugged <= 1'b1;
    slow <= 1'b1;
    tick(6);
    rd(ADDR_PORT_STATUS, 5'h01, 1'b1);
    wr(32'h0000_0000);
    rd(ADDR_PORT_STATUS, 5'h01, 1'b1);
    wr(32'h0001_0000);
    rd(ADDR_PORT_STATUS, 5'h00, 1'b1);
    wr(32'h0000_0010);
    #1 chk({31'h0, rst_act}, 32'h1);
    tick(RST_N - 6);
    rd(ADDR_PORT_STATUS, 5'h00, 1'b1);
    tick(8);
    rd(ADDR_PORT_STATUS, 5'h10, 1'b1);
    wr(CLR);
    @(posedge mclk) resume_eop_done <= 1'b1;
    @(posedge mclk) resume_eop_done <= 1'b0;
    tick(RSY_N - 4);
    rd(ADDR_PORT_STATUS, 5'h00, 1'b1);
    tick(8);
    rd(ADDR_PORT_STATUS, 5'h04, 1'b1);
    wr(32'h0000_0010);
    tick(RST_N + 6);
    rd(ADDR_PORT_STATUS, 5'h10, 1'b1);
    wr(CLR);
    per_port_oc <= 1'b1;
    oc <= 1'b1;
    tick(6);
    rd(ADDR_PORT_STATUS, 5'h08, 1'b1);
    wr(CLR);
    oc <= 1'b0;
    tick(6);
    rd(ADDR_PORT_STATUS, 5'h08, 1'b1);
    wr(CLR);
    wr(32'h0000_0002);
    tick(2);
    chk(32'(n_en), 32'h1);
    wr(32'h0000_0004);
    tick(2);
    chk(32'(n_sus), 32'h1);
    rd(ADDR_PORT_STATUS, 5'h00, 1'b1);
    @(posedge mclk) hw_enable_loss <= 1'b1;
    @(posedge mclk) hw_enable_loss <= 1'b0;
    rd(ADDR_PORT_STATUS, 5'h02, 1'b1);
    // The clear and a fresh loss land on the same edge; the loss must survive.
    @(posedge mclk);
    bus <= '{ADDR_PORT_WRITE, 32'h0002_0000, 1'b1, 1'b0};
    hw_enable_loss <= 1'b1;
    @(posedge mclk);
    bus <= '0;
    hw_enable_loss <= 1'b0;
    rd(ADDR_PORT_STATUS, 5'h02, 1'b1);
    xfer_busy <= 1'b1;
    wr(32'h0002_0000);
    tick(3);
    rd(ADDR_PORT_STATUS, 5'h02, 1'b1);
    xfer_busy <= 1'b0;
    tick(3);
    rd(ADDR_PORT_STATUS, 5'h00, 1'b1);
    wr(32'h0000_0200);
    tick(2);
    chk(32'(n_off), 32'h1);
    plugged <= 1'b0;
    slow <= 1'b0;
    tick(6);
    rd(ADDR_PORT_STATUS, 5'h01, 1'b0);
    foreach (port_cmd[i]) begin
      wr(CLR);
      wr(32'h1 << port_cmd[i]);
      rd(ADDR_PORT_STATUS, 5'h01, 1'b0);
    end
    chk(32'(n_en + n_sus), 32'h2);
    chk({31'h0, rst_act}, 32'h0);
    wr(CLR);
    fixed <= 1'b1;
    plugged <= 1'b1;
    tick(6);
    rd(ADDR_PORT_STATUS, 5'h00, 1'b0);
    @(posedge mclk) hub_reset_done <= 1'b1;
    @(posedge mclk) hub_reset_done <= 1'b0;
    tick(3);
    rd(ADDR_PORT_STATUS, 5'h01, 1'b0);
    // A clear written while the clock enable is low must not land.
    ce <= 1'b0;
    wr(CLR);
    ce <= 1'b1;
    rd(ADDR_PORT_STATUS, 5'h01, 1'b0);
    results();
  end
endmodule
